// ==== logic/pif_cfg.svh ====
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define PIF_ADDR_FLAGS      8'h0C
`define PIF_ADDR_ENABLES    8'h8C
`define PIF_ADDR_CORE_CTRL  8'h90
`define PIF_ADDR_IRQ_STATUS 8'h94
`define PIF_ADDR_IRQ_MASK   8'h98

// ----------------------------------------------------------------------------
// Flag and enable bit positions (enables mirror the flags)
// ----------------------------------------------------------------------------
`define PIF_BIT_TIMER_ONE   0
`define PIF_BIT_PERIOD      1
`define PIF_BIT_CAPCMP      2
`define PIF_BIT_SERIAL      3
`define PIF_BIT_CONVERTER   6

// Bits 7, 5 and 4 are unimplemented and read as zero
`define PIF_IMPL_MASK       8'h4F

// ----------------------------------------------------------------------------
// Core interrupt control bit positions
// ----------------------------------------------------------------------------
`define PIF_BIT_PERIPH_EN   6
`define PIF_BIT_GLOBAL_EN   7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PIF_RST_FLAGS       8'h00
`define PIF_RST_ENABLES     8'h00
`define PIF_RST_CORE_CTRL   8'h00
`define PIF_RST_IRQ_STATUS  8'h00
`define PIF_RST_IRQ_MASK    8'h00
`define PIF_RST_RDATA       32'h0000_0000

`endif

// ==== logic/pif_pkg.sv ====
package pif_pkg;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  // Operating mode of the capture/compare unit
  typedef enum logic [1:0] {
    CCP_OFF,
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_PWM
  } ccp_mode_t;

  // One byte of flags, enables, status or mask
  typedef logic [7:0] flag_byte_t;

endpackage

// ==== logic/flag_bank_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries event pulses and software writes into the flag bank
interface flag_bank_if;
  logic [7:0] set_evt;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] flags;

  modport bank (input set_evt, input wr_en, input wr_data, output flags);
  modport ctrl (output set_evt, output wr_en, output wr_data, input flags);
endinterface

`default_nettype wire

// ==== logic/flag_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pif_cfg.svh"

module flag_bank (
  input  wire logic   i_core_clk,
  input  wire logic   i_rst_n,
  flag_bank_if.bank   bus
);
  import pif_pkg::*;

  // A literal cannot be bit-selected, so the mask is held as a constant
  localparam flag_byte_t IMPL = `PIF_IMPL_MASK;

  flag_byte_t flags;
  flag_byte_t next_flags;

  // ---------------------------------------------------------------------------
  // Per-bit sticky flags
  // ---------------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      // Set wins over a software clear in the same cycle, so no event is lost
      always_comb begin
        if (!IMPL[b]) begin
          next_flags[b] = 1'b0;
        end else if (bus.set_evt[b]) begin
          next_flags[b] = 1'b1;
        end else if (bus.wr_en) begin
          next_flags[b] = bus.wr_data[b];
        end else begin
          next_flags[b] = flags[b];
        end
      end
    end
  endgenerate

  // Registers only; synchronous reset clears every flag
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      flags <= `PIF_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  assign bus.flags = flags;

endmodule

`default_nettype wire

// ==== logic/peripheral_interrupt_flags.sv ====
// Overview of operation
// - Flags set regardless of any enable bit
// - Bit 6 sets on conversion done, sticky
// - Bit 3 sets on serial transfer done, sticky
// - Bit 2 sets on capture in capture mode
// - Bit 2 sets on compare match in compare mode
// - Bit 1 sets on timer two period match
// - Request needs peripheral enable plus source enable
// - Companion enable register mirrors flag bit positions
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pif_cfg.svh"

module peripheral_interrupt_flags #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // Wishbone classic slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADDR_W-1:0] i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  // Peripheral events, one-cycle pulses on the core clock
  input  wire logic              i_converter_done,
  input  wire logic              i_serial_done,
  input  wire logic              i_capture_event,
  input  wire logic              i_compare_match,
  input  wire pif_pkg::ccp_mode_t i_ccp_mode,
  input  wire logic              i_period_match,
  input  wire logic              i_timer_one_overflow,
  // Toward the processor core
  output logic                   o_periph_irq_req,
  output logic                   o_core_irq,
  output logic                   o_irq
);
  import pif_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode constants
  // ---------------------------------------------------------------------------
  // Addresses sized to the bus once, so every compare is width-exact
  localparam logic [ADDR_W-1:0] ADR_FLAGS      = ADDR_W'(`PIF_ADDR_FLAGS);
  localparam logic [ADDR_W-1:0] ADR_ENABLES    = ADDR_W'(`PIF_ADDR_ENABLES);
  localparam logic [ADDR_W-1:0] ADR_CORE_CTRL  = ADDR_W'(`PIF_ADDR_CORE_CTRL);
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = ADDR_W'(`PIF_ADDR_IRQ_STATUS);
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK   = ADDR_W'(`PIF_ADDR_IRQ_MASK);
  // Only the two enable bits of the control byte are stored
  localparam flag_byte_t        CTRL_RST       = `PIF_RST_CORE_CTRL;
  localparam flag_byte_t        IMPL_MASK      = `PIF_IMPL_MASK;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  flag_bank_if fb ();

  flag_byte_t  enables;
  flag_byte_t  next_enables;
  logic [1:0]  core_ctrl;
  logic [1:0]  next_core_ctrl;
  flag_byte_t  irq_status;
  flag_byte_t  next_irq_status;
  flag_byte_t  irq_mask;
  flag_byte_t  next_irq_mask;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Bus and event glue
  logic        req;
  logic        acc;
  logic        wr_lane0;
  logic        capcmp_evt;
  flag_byte_t  events;
  flag_byte_t  pending;
  logic        global_en;
  logic        periph_en;
  logic        status_rd;

  // ---------------------------------------------------------------------------
  // Event collection
  // ---------------------------------------------------------------------------
  // The shared capture/compare flag means different things per mode; in
  // PWM mode nothing sets it, so stray strobes cannot leave it pending.
  always_comb begin
    capcmp_evt = 1'b0;
    unique case (i_ccp_mode)
      CCP_CAPTURE: capcmp_evt = i_capture_event;
      CCP_COMPARE: capcmp_evt = i_compare_match;
      CCP_OFF:     capcmp_evt = 1'b0;
      CCP_PWM:     capcmp_evt = 1'b0;
    endcase
  end

  // Events map straight onto flag positions, with no enable in the path
  always_comb begin
    events                       = 8'h00;
    events[`PIF_BIT_CONVERTER]   = i_converter_done;
    events[`PIF_BIT_SERIAL]      = i_serial_done;
    events[`PIF_BIT_CAPCMP]      = capcmp_evt;
    events[`PIF_BIT_PERIOD]      = i_period_match;
    events[`PIF_BIT_TIMER_ONE]   = i_timer_one_overflow;
  end

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // A request is taken on the edge where ack is high, so writes and the
  // read clear act exactly once per access
  assign req      = i_wb_cyc && i_wb_stb;
  assign acc      = req && ack;
  assign wr_lane0 = acc && i_wb_we && i_wb_sel[0];

  // Flag register write path into the bank
  assign fb.set_evt = events;
  assign fb.wr_en   = wr_lane0 && (i_wb_adr == ADR_FLAGS);
  assign fb.wr_data = i_wb_dat[7:0];

  flag_bank u_flag_bank (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .bus        (fb)
  );

  // ---------------------------------------------------------------------------
  // Software register next values
  // ---------------------------------------------------------------------------
  // Writes land only on the acknowledged edge, low byte lane only
  always_comb begin
    next_enables   = enables;
    next_core_ctrl = core_ctrl;
    next_irq_mask  = irq_mask;
    if (wr_lane0 && (i_wb_adr == ADR_ENABLES)) begin
      next_enables = i_wb_dat[7:0] & IMPL_MASK;
    end
    if (wr_lane0 && (i_wb_adr == ADR_CORE_CTRL)) begin
      next_core_ctrl = {i_wb_dat[`PIF_BIT_GLOBAL_EN], i_wb_dat[`PIF_BIT_PERIPH_EN]};
    end
    if (wr_lane0 && (i_wb_adr == ADR_IRQ_MASK)) begin
      next_irq_mask = i_wb_dat[7:0] & IMPL_MASK;
    end
  end

  // Status is cleared by a completed read only, never at the request edge
  assign status_rd = acc && !i_wb_we && (i_wb_adr == ADR_IRQ_STATUS);

  // Sticky status: cleared by a read, but a new event in that cycle wins
  always_comb begin
    next_irq_status = irq_status;
    if (status_rd) begin
      next_irq_status = 8'h00;
    end
    next_irq_status = (next_irq_status | events) & IMPL_MASK;
  end

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after; unmapped
  // addresses are acknowledged and read as zero so the bus never hangs
  always_comb begin
    next_ack   = req && !ack;
    next_rdata = rdata;
    if (req && !ack) begin
      next_rdata = 32'h0000_0000;
      unique case (i_wb_adr)
        ADR_FLAGS:      next_rdata[7:0] = fb.flags;
        ADR_ENABLES:    next_rdata[7:0] = enables;
        ADR_CORE_CTRL: begin
          next_rdata[`PIF_BIT_GLOBAL_EN] = core_ctrl[1];
          next_rdata[`PIF_BIT_PERIPH_EN] = core_ctrl[0];
        end
        ADR_IRQ_STATUS: next_rdata[7:0] = irq_status;
        ADR_IRQ_MASK:   next_rdata[7:0] = irq_mask;
        default:              next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  // Synchronous reset returns all software state to its reset value
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      enables    <= `PIF_RST_ENABLES;
      core_ctrl  <= {CTRL_RST[`PIF_BIT_GLOBAL_EN], CTRL_RST[`PIF_BIT_PERIPH_EN]};
      irq_status <= `PIF_RST_IRQ_STATUS;
      irq_mask   <= `PIF_RST_IRQ_MASK;
      ack        <= 1'b0;
      rdata      <= `PIF_RST_RDATA;
    end else begin
      enables    <= next_enables;
      core_ctrl  <= next_core_ctrl;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      ack        <= next_ack;
      rdata      <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt gating
  // ---------------------------------------------------------------------------
  // Enabling a source with a stale flag fires at once; software is expected
  // to clear the flag first, the hardware does not guard against it
  assign global_en        = core_ctrl[1];
  assign periph_en        = core_ctrl[0];
  assign pending          = fb.flags & enables;
  assign o_periph_irq_req = periph_en && (|pending);
  assign o_core_irq       = global_en && o_periph_irq_req;
  // Status interrupt ignores the flag enables and the core control bits
  assign o_irq            = |(irq_status & irq_mask);
  assign o_wb_ack         = ack;
  assign o_wb_dat         = rdata;

endmodule

`default_nettype wire

// ==== sim/pif_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pif_cfg.svh"

module pif_chk
  import pif_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              i_core_clk,
  input wire logic              i_rst_n,
  input wire logic              i_wb_cyc,
  input wire logic              i_wb_stb,
  input wire logic              i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [31:0]       o_wb_dat,
  input wire logic              o_wb_ack,
  input wire logic              i_converter_done,
  input wire logic              i_serial_done,
  input wire logic              i_capture_event,
  input wire logic              i_compare_match,
  input wire ccp_mode_t         i_ccp_mode,
  input wire logic              i_period_match,
  input wire logic              i_timer_one_overflow,
  input wire logic              o_periph_irq_req,
  input wire logic              o_core_irq
);
  // ---------------------------------------------------------------------------
  // Bus and flag properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // A flag read seen by the slave
  sequence rd_flags;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && i_wb_adr == ADDR_W'(`PIF_ADDR_FLAGS);
  endsequence
  // No write lands in between, so the set must still show
  sequence late_rd;
    !o_wb_ack ##1 rd_flags;
  endsequence

  a_ack_one_shot: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_ack_next_cycle: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_conv_flag_set: assert property (i_converter_done ##1 late_rd |=> o_wb_dat[6]) else $error("bit6");
  a_serial_flag_set: assert property (i_serial_done ##1 late_rd |=> o_wb_dat[3]) else $error("bit3");
  a_capture_flag_set: assert property (i_capture_event && i_ccp_mode == CCP_CAPTURE ##1 late_rd
    |=> o_wb_dat[2]) else $error("capture bit2");
  a_compare_flag_set: assert property (i_compare_match && i_ccp_mode == CCP_COMPARE ##1 late_rd
    |=> o_wb_dat[2]) else $error("compare bit2");
  a_period_flag_set: assert property (i_period_match ##1 late_rd |=> o_wb_dat[1]) else $error("bit1");
  a_ovf_flag_set: assert property (i_timer_one_overflow ##1 late_rd |=> o_wb_dat[0]) else $error("bit0");
  a_unused_bits_zero: assert property (rd_flags |=> (o_wb_dat & 32'hFFFF_FFB0) == 32'h0) else $error("bits");
  a_core_gated: assert property (o_core_irq |-> o_periph_irq_req) else $error("core irq");
endmodule

bind peripheral_interrupt_flags pif_chk #(.ADDR_W(ADDR_W)) chk_u (.i_core_clk, .i_rst_n, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_converter_done, .i_serial_done, .i_capture_event,
  .i_compare_match, .i_ccp_mode, .i_period_match, .i_timer_one_overflow, .o_periph_irq_req, .o_core_irq);

`default_nettype wire

// ==== sim/event_sources.sv ====
`timescale 1ns/1ps
`default_nettype none

// Peripheral sources: fire bits 6, 4, 3, 2, 1 and 0 each become one core-clock pulse; bits 7 and 5 drive nothing
module event_sources (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_fire,
  output logic            o_conv,
  output logic            o_serial,
  output logic            o_capture,
  output logic            o_compare,
  output logic            o_period,
  output logic            o_ovf
);
  // Registered so pulses leave right after an edge, like real peripherals
  always_ff @(posedge i_core_clk) begin
    o_conv    <= i_fire[6];
    o_serial  <= i_fire[3];
    o_capture <= i_fire[2];
    o_compare <= i_fire[4];
    o_period  <= i_fire[1];
    o_ovf     <= i_fire[0];
  end
endmodule

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pif_pkg::*;
  logic        clk, rst_n, cyc, stb, we, ack, preq, cirq, irq, cv, sr, cp, cm, pm, ov;
  logic [7:0]  adr, fire;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  ccp_mode_t   mode;
  int          n_fail, n_checks, cyc_n, r, fl, en, ct, st, mk;
  logic [7:0]  am [6] = '{8'h0C, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h40};

  event_sources src_u (.i_core_clk(clk), .i_fire(fire), .o_conv(cv), .o_serial(sr), .o_capture(cp),
    .o_compare(cm), .o_period(pm), .o_ovf(ov));
  peripheral_interrupt_flags dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_converter_done(cv), .i_serial_done(sr), .i_capture_event(cp), .i_compare_match(cm),
    .i_ccp_mode(mode), .i_period_match(pm), .i_timer_one_overflow(ov), .o_periph_irq_req(preq),
    .o_core_irq(cirq), .o_irq(irq));

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      results();
    end
  end
  function automatic int xs();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return r;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Interrupt outputs against the model, sampled at the settled negedge
  task automatic outs();
    @(negedge clk);
    chk({preq, cirq, irq}, {ct[6] && (fl & en) != 0, ct[7] && ct[6] && (fl & en) != 0, (st & mk) != 0});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t == 20) n_fail++;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    wb(1'b1, a, d, 4'h1);
    case (a)
      8'h0C: fl = d & 'h4F;
      8'h8C: en = d & 'h4F;
      8'h90: ct = d & 'hC0;
      8'h98: mk = d & 'h4F;
      default: ;
    endcase
    outs();
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'h1);
    chk(q, a == 8'h0C ? fl : a == 8'h8C ? en : a == 8'h90 ? ct : a == 8'h94 ? st : a == 8'h98 ? mk : 0);
    if (a == 8'h94) st = 0;
    outs();
  endtask
  // Pulse sources; bit 2 counts only in the matching unit mode
  task automatic ev(input logic [7:0] f, input ccp_mode_t m);
    int b;
    @(posedge clk);
    fire <= f;
    mode <= m;
    @(posedge clk);
    fire <= 8'h00;
    @(posedge clk);
    b = f & 'h4B;
    if (f[2] && m == CCP_CAPTURE || f[4] && m == CCP_COMPARE) b |= 4;
    fl |= b;
    st |= b;
    outs();
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, cyc, stb, we, adr, wdat, fire, sel} = '0;
    mode = CCP_OFF;
    {n_fail, n_checks, cyc_n, fl, en, ct, st, mk} = '0;
    r = 32'hD6EC;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (am[i]) rd(am[i]);
    foreach (am[i]) if (i != 3) wr(am[i], i == 2 ? 'hC0 : i == 4 ? 'h4F : 'hFF);
    foreach (am[i]) rd(am[i]);
    foreach (am[i]) if (i != 3) wr(am[i], 0);
    // A write without byte lane 0 must leave the enables alone
    wb(1'b1, 8'h8C, 32'hFF, 4'hE);
    rd(8'h8C);
    // Events landing on the same edge as a flag clear must win
    fork
      wb(1'b1, 8'h0C, 32'h0, 4'h1);
      begin
        @(posedge clk);
        fire <= 8'h41;
        @(posedge clk);
        fire <= 8'h00;
      end
    join
    fl = 'h41;
    st |= 'h41;
    rd(8'h0C);
    rd(8'h94);
    $display("test registers done");
    ev(8'h5F, CCP_CAPTURE);
    rd(8'h0C);
    for (int m = 0; m < 4; m++) begin
      wr(8'h0C, 0);
      ev(8'h14, ccp_mode_t'(m));
      rd(8'h0C);
    end
    $display("test events done");
    for (int k = 0; k < 200; k++) begin
      int x;
      x = xs();
      case (x[1:0])
        2'd0: ev(x[23:16] & 8'h5F, ccp_mode_t'(x[25:24]));
        2'd1: if ($unsigned(x) % 6 != 3) wr(am[$unsigned(x) % 6], x[15:8] & (x[12] ? 'hC0 : 'h4F));
        default: rd(am[$unsigned(x) % 6]);
      endcase
    end
    $display("test random done");
    results();
  end
endmodule

`default_nettype wire
